//--- verilog/rtc_consts.svh
/*
 Offsets, reset values and timing figures of the calendar clock.
 Assumes a 32-bit APB slave decoding a 12-bit byte address.
*/
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// register byte offsets
`define RTC_YEAR_OFS   12'h000
`define RTC_MONTH_OFS  12'h004
`define RTC_DAY_OFS    12'h008
`define RTC_DOW_OFS    12'h00c
`define RTC_HOUR_OFS   12'h010
`define RTC_MIN_OFS    12'h014
`define RTC_SEC_OFS    12'h018
`define RTC_HMS_OFS    12'h01c
`define RTC_CALIB_OFS  12'h020
`define RTC_CTRL_OFS   12'h024
`define RTC_IRQST_OFS  12'h028
`define RTC_IRQMSK_OFS 12'h02c

// control command word: selector in [15:8], argument in [7:0]
`define RTC_CMD_SEL    8'hfd

// status bits: second tick, error raised, new day
`define RTC_EV_SEC     0
`define RTC_EV_ERR     1
`define RTC_EV_DAY     2

// reset values: 2000-01-01, a Saturday, 00:00:00
`define RTC_RST_YEAR   16'h07d0
`define RTC_RST_MONTH  4'h1
`define RTC_RST_DAY    5'h01
`define RTC_RST_DOW    3'h6

// timing
`define RTC_CLK_HZ     40000000
`define RTC_XTAL_HZ    32768
`define RTC_SEC_S      1
`define RTC_CAL_HOURS  72
`define RTC_SEC_PER_H  3600
`define RTC_LOST_S     4'hf

`endif

//--- verilog/rtc_pkg.sv
/*
 Types of the calendar clock: command arguments, time fields and the
 state records of the clock and its prescaler.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rtc_pkg;

   typedef enum logic [7:0] {
      ARG_STOP  = 8'h00,
      ARG_RUN   = 8'h01,
      ARG_NOREF = 8'h02,
      ARG_REF   = 8'h03
   } cmd_arg_e;

   typedef struct packed {
      logic [15:0] year;
      logic [3:0]  month;
      logic [4:0]  day;
      logic [2:0]  dow;
      logic [4:0]  hour;
      logic [5:0]  minute;
      logic [5:0]  second;
   } time_s;

   typedef struct packed {
      time_s              tm;
      logic signed [15:0] calib;
      logic [18:0]        calAcc;
      logic               run;
      logic               autoRef;
      logic [3:0]         pinA;
      logic [3:0]         pinB;
      logic [1:0]         capCnt;
      logic [3:0]         missCnt;
      logic               lostQ;
      logic               errQ;
      logic               ledQ;
      logic [2:0]         irqSt;
      logic [2:0]         irqMask;
      logic               irqQ;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
   } cal_state_s;

   typedef struct packed {
      logic        xa;
      logic        xb;
      logic        xc;
      logic        useQ;
      logic [25:0] cnt;
      logic        tick;
   } presc_state_s;

endpackage

//--- verilog/rtc_prescaler.sv
/*
 Seconds prescaler: one-cycle tick per second, from the 32.768 kHz
 crystal of the backup module or from the system clock.
 Assumes clk well above twice the crystal rate.
*/
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_prescaler #(
   parameter int TICK_CYCLES = `RTC_SEC_S * `RTC_CLK_HZ,
   parameter int XTAL_DIV    = `RTC_SEC_S * `RTC_XTAL_HZ
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic xtalIn,
   input  wire logic useXtal,
   output logic      tick
);

   rtc_pkg::presc_state_s s_q;
   rtc_pkg::presc_state_s s_d;
   logic [25:0]           limit;

   // count crystal edges or clock cycles up to one second
   always_comb begin
      s_d = s_q;
      s_d.xa = xtalIn;
      s_d.xb = s_q.xa;
      s_d.xc = s_q.xb;
      s_d.useQ = useXtal;
      s_d.tick = 1'b0;
      limit = useXtal ? 26'(XTAL_DIV - 1) : 26'(TICK_CYCLES - 1);
      // restart on a source swap so no short second slips out
      if (useXtal != s_q.useQ) begin
         s_d.cnt = '0;
      end else if (!useXtal || (s_q.xb & ~s_q.xc)) begin   // [RULE8]
         if (s_q.cnt >= limit) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 26'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule

//--- verilog/calendar_clock.sv
/*
 Calendar clock with seconds trim, run/stop and backup-module source
 control, error flag and light, behind an APB slave.
 Assumes pins modulePresent, batteryOk, timeLost, clockCorrupt and
 xtalIn come from outside the clock domain.
*/
// The register addresses and the APB slave port were decided locally.
// How it works
// (RULE1) The error flag rises when the clock is corrupt or lost or the battery is missing.
// (RULE2) The error light follows the error flag.
// (RULE3) Writing a date or time field loads it into the running clock.
// (RULE4) Every date and time field reads back as a plain integer.
// (RULE5) The packed time reads as hours*10000 + minutes*100 + seconds.
// (RULE6) A signed trim of seconds is spread over each 72 hours.
// (RULE7) A positive trim adds seconds, a negative one drops them.
// (RULE8) The backup module times seconds by dividing its 32.768 kHz crystal.
// (RULE9) Command 253 with argument 0 stops the clock and with 1 runs it.
// (RULE10) Command 253 with 2 disables and with 3 enables backup-module refresh.
// (RULE11) A clock set and power-cycled on intact hardware reports no error.
// (RULE12) Day of week runs 1 Monday to 7 Sunday and the year holds four digits.
// (RULE13) A battery missing over 15 seconds marks the time lost.
// (RULE14) A fitted backup module is detected and used as time source.
// (RULE15) Fields roll over with month lengths, leap years and weekday wrap.
// (RULE16) A stopped clock holds its fields and suspends the trim.
`timescale 1ns/1ps
`include "rtc_consts.svh"

module calendar_clock #(
   parameter int TICK_CYCLES  = `RTC_SEC_S * `RTC_CLK_HZ,
   parameter int XTAL_DIV     = `RTC_SEC_S * `RTC_XTAL_HZ,
   parameter int CAL_WINDOW_S = `RTC_CAL_HOURS * `RTC_SEC_PER_H
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        xtalIn,
   input  wire logic        modulePresent,
   input  wire logic        batteryOk,
   input  wire logic        timeLost,
   input  wire logic        clockCorrupt,
   output logic             irq,
   output logic             errFlag,
   output logic             errLed
);

   rtc_pkg::cal_state_s s_q;
   rtc_pkg::cal_state_s s_d;
   logic                tick;
   logic                apbWr;
   logic [15:0]         absCal;
   logic [18:0]         calSum;
   logic                calHit;
   logic [18:0]         win;

   // leap year of the full year
   function automatic logic leap(input logic [15:0] y);
      leap = ((y % 16'h4) == 16'h0 && (y % 16'h64) != 16'h0)
             || (y % 16'h190) == 16'h0;
   endfunction

   function automatic logic [4:0] month_days(input logic [15:0] y,
                                             input logic [3:0]  m);
      case (m)
         4'h2: month_days = leap(y) ? 5'h1d : 5'h1c;
         4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
         default: month_days = 5'h1f;
      endcase
   endfunction

   // advance one second with full calendar carry
   function automatic rtc_pkg::time_s step(input rtc_pkg::time_s t);
      rtc_pkg::time_s n;
      n = t;
      if (t.second < 6'h3b) begin
         n.second = t.second + 6'h1;
      end else begin
         n.second = 6'h0;
         if (t.minute < 6'h3b) begin
            n.minute = t.minute + 6'h1;
         end else begin
            n.minute = 6'h0;
            if (t.hour < 5'h17) begin
               n.hour = t.hour + 5'h1;
            end else begin
               n.hour = 5'h0;
               n.dow = (t.dow >= 3'h7) ? 3'h1 : t.dow + 3'h1;   // [RULE12]
               if (t.day < month_days(t.year, t.month)) begin
                  n.day = t.day + 5'h1;
               end else begin
                  n.day = 5'h1;
                  if (t.month < 4'hc) begin
                     n.month = t.month + 4'h1;
                  end else begin
                     n.month = 4'h1;
                     n.year = t.year + 16'h1;
                  end
               end
            end
         end
      end
      step = n;
   endfunction

   // packed hhmmss as one decimal integer
   function automatic logic [31:0] hhmmss(input rtc_pkg::time_s t);
      hhmmss = 32'(t.hour) * 32'h2710 + 32'(t.minute) * 32'h64 + 32'(t.second);
   endfunction

   // source: crystal of a fitted module while refresh is enabled
   rtc_prescaler #(
      .TICK_CYCLES (TICK_CYCLES),
      .XTAL_DIV    (XTAL_DIV)
   ) u_presc (
      .clk     (clk),
      .rst_n   (rst_n),
      .xtalIn  (xtalIn),
      .useXtal (s_q.pinB[0] & s_q.autoRef),   // [RULE14] [RULE10]
      .tick    (tick)
   );

   // a write takes effect on the edge that completes the access
   assign apbWr = psel & penable & s_q.pready & pwrite;

   // trim accumulator: |trim| per second against the window
   assign win = 19'(CAL_WINDOW_S);
   assign absCal = s_q.calib[15] ? 16'(-s_q.calib) : s_q.calib;
   assign calSum = s_q.calAcc + {3'h0, absCal};
   assign calHit = calSum >= win;   // [RULE6]

   always_comb begin
      logic [2:0] evt;
      logic [2:0] clr;
      evt = '0;
      clr = '0;
      s_d = s_q;

      // pin synchronisers: corrupt, lost strap, battery, module present
      s_d.pinA = {clockCorrupt, timeLost, batteryOk, modulePresent};
      s_d.pinB = s_q.pinA;

      // lost strap is caught once the synchroniser has filled
      if (s_q.capCnt != 2'h3) begin
         s_d.capCnt = s_q.capCnt + 2'h1;
      end
      if (s_q.capCnt == 2'h2 && s_q.pinB[2]) begin
         s_d.lostQ = 1'b1;   // [RULE13]
      end

      // only a power cycle clears the lost mark
      if (s_q.pinB[1]) begin
         s_d.missCnt = '0;
      end else if (tick) begin
         if (s_q.missCnt == `RTC_LOST_S) begin
            s_d.lostQ = 1'b1;   // [RULE13] [RULE11]
         end else begin
            s_d.missCnt = s_q.missCnt + 4'h1;
         end
      end

      // seconds advance; a stopped clock freezes time and trim
      if (tick && s_q.run) begin   // [RULE16]
         s_d.calAcc = calHit ? calSum - win : calSum;   // [RULE6]
         if (!(calHit && s_q.calib < 0)) begin
            s_d.tm = step(s_q.tm);   // [RULE15]
         end
         if (calHit && s_q.calib > 0) begin
            s_d.tm = step(s_d.tm);   // [RULE7]
         end
         evt[`RTC_EV_SEC] = 1'b1;
         evt[`RTC_EV_DAY] = s_d.tm.day != s_q.tm.day;
      end

      // error flag and light
      s_d.errQ = s_q.lostQ | s_q.pinB[3] | ~s_q.pinB[1];   // [RULE1]
      s_d.ledQ = s_q.lostQ | s_q.pinB[3] | ~s_q.pinB[1];   // [RULE2]
      evt[`RTC_EV_ERR] = s_d.errQ & ~s_q.errQ;

      // read side: data latched on the same edge that raises pready
      s_d.pready = psel & penable & ~s_q.pready;
      if (psel & penable & ~s_q.pready) begin
         s_d.pslverr = 1'b0;
         case (paddr)   // [RULE4]
            `RTC_YEAR_OFS:   s_d.prdata = 32'(s_q.tm.year);
            `RTC_MONTH_OFS:  s_d.prdata = 32'(s_q.tm.month);
            `RTC_DAY_OFS:    s_d.prdata = 32'(s_q.tm.day);
            `RTC_DOW_OFS:    s_d.prdata = 32'(s_q.tm.dow);
            `RTC_HOUR_OFS:   s_d.prdata = 32'(s_q.tm.hour);
            `RTC_MIN_OFS:    s_d.prdata = 32'(s_q.tm.minute);
            `RTC_SEC_OFS:    s_d.prdata = 32'(s_q.tm.second);
            `RTC_HMS_OFS:    s_d.prdata = hhmmss(s_q.tm);   // [RULE5]
            `RTC_CALIB_OFS:  s_d.prdata = 32'(s_q.calib);
            `RTC_CTRL_OFS:   s_d.prdata = {28'h0, s_q.errQ, s_q.pinB[0],
                                           s_q.autoRef, s_q.run};
            `RTC_IRQST_OFS:  s_d.prdata = {29'h0, s_q.irqSt};
            `RTC_IRQMSK_OFS: s_d.prdata = {29'h0, s_q.irqMask};
            default: begin
               s_d.prdata = '0;
               s_d.pslverr = 1'b1;
            end
         endcase
      end

      // write side: a field write overrides a same-cycle tick
      if (apbWr) begin
         case (paddr)   // [RULE3]
            `RTC_YEAR_OFS:   s_d.tm.year = pwdata[15:0];
            `RTC_MONTH_OFS:  s_d.tm.month = pwdata[3:0];
            `RTC_DAY_OFS:    s_d.tm.day = pwdata[4:0];
            `RTC_DOW_OFS:    s_d.tm.dow = pwdata[2:0];
            `RTC_HOUR_OFS:   s_d.tm.hour = pwdata[4:0];
            `RTC_MIN_OFS:    s_d.tm.minute = pwdata[5:0];
            `RTC_SEC_OFS:    s_d.tm.second = pwdata[5:0];
            `RTC_CALIB_OFS:  s_d.calib = pwdata[15:0];
            `RTC_CTRL_OFS: begin
               // other selectors and arguments are ignored
               if (pwdata[15:8] == `RTC_CMD_SEL) begin
                  case (rtc_pkg::cmd_arg_e'(pwdata[7:0]))
                     rtc_pkg::ARG_STOP:  s_d.run = 1'b0;   // [RULE9]
                     rtc_pkg::ARG_RUN:   s_d.run = 1'b1;   // [RULE9]
                     rtc_pkg::ARG_NOREF: s_d.autoRef = 1'b0;   // [RULE10]
                     rtc_pkg::ARG_REF:   s_d.autoRef = 1'b1;   // [RULE10]
                     default: ;
                  endcase
               end
            end
            `RTC_IRQST_OFS:  clr = pwdata[2:0];
            `RTC_IRQMSK_OFS: s_d.irqMask = pwdata[2:0];
            default: ;
         endcase
      end

      // sticky status; a new event beats a same-cycle clear
      s_d.irqSt = (s_q.irqSt & ~clr) | evt;
      s_d.irqQ = |(s_d.irqSt & s_d.irqMask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.tm.year <= `RTC_RST_YEAR;
         s_q.tm.month <= `RTC_RST_MONTH;
         s_q.tm.day <= `RTC_RST_DAY;
         s_q.tm.dow <= `RTC_RST_DOW;
         s_q.run <= 1'b1;
         s_q.autoRef <= 1'b1;
         // both stages start at a fitted battery, so release shows no false error
         s_q.pinA <= 4'h2;
         s_q.pinB <= 4'h2;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq = s_q.irqQ;
   assign errFlag = s_q.errQ;
   assign errLed = s_q.ledQ;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   no_battery_a: assert property (!s_q.pinB[1] |=> errFlag) // [RULE1]
      else $error("missing battery did not raise the error flag");

   err_light_a: assert property (errFlag == errLed) // [RULE2]
      else $error("error light differs from error flag");

   sec_load_a: assert property ( // [RULE3]
      apbWr && paddr == `RTC_SEC_OFS |=> s_q.tm.second == $past(pwdata[5:0]))
      else $error("seconds write not loaded");

   hour_read_a: assert property ( // [RULE4]
      psel && penable && !pready && paddr == `RTC_HOUR_OFS
      |=> pready && prdata == 32'($past(s_q.tm.hour)))
      else $error("hour read returned wrong value");

   packed_read_a: assert property ( // [RULE5]
      psel && penable && !pready && paddr == `RTC_HMS_OFS
      |=> prdata == hhmmss($past(s_q.tm)))
      else $error("packed time read wrong");

   trim_gain_a: assert property ( // [RULE6] [RULE7]
      tick && s_q.run && calHit && s_q.calib > 0 && !apbWr
      && s_q.tm.second < 6'h3a |=> s_q.tm.second == $past(s_q.tm.second) + 6'h2)
      else $error("positive trim did not add a second");

   trim_drop_a: assert property ( // [RULE7]
      tick && s_q.run && calHit && s_q.calib < 0 && !apbWr |=> $stable(s_q.tm))
      else $error("negative trim did not drop a second");

   trim_bound_a: assert property (s_q.calAcc < win) // [RULE6]
      else $error("trim accumulator out of range");

   stop_cmd_a: assert property ( // [RULE9]
      apbWr && paddr == `RTC_CTRL_OFS && pwdata[15:0] == 16'hfd00 |=> !s_q.run)
      else $error("stop command did not stop the clock");

   refresh_cmd_a: assert property ( // [RULE10]
      apbWr && paddr == `RTC_CTRL_OFS && pwdata[15:0] == 16'hfd03 |=> s_q.autoRef)
      else $error("refresh enable command ignored");

   stop_hold_a: assert property ( // [RULE16]
      !s_q.run && !apbWr |=> $stable(s_q.tm) && $stable(s_q.calAcc))
      else $error("stopped clock moved");

   week_wrap_a: assert property ( // [RULE15] [RULE12]
      tick && s_q.run && !calHit && !apbWr && s_q.tm.dow == 3'h7
      && s_q.tm.hour == 5'h17 && s_q.tm.minute == 6'h3b && s_q.tm.second == 6'h3b
      |=> s_q.tm.dow == 3'h1 && s_q.tm.hour == 5'h0)
      else $error("weekday did not wrap at midnight");

   lost_hold_a: assert property (s_q.lostQ |-> ##2 errFlag && s_q.lostQ) // [RULE13]
      else $error("lost time not kept as error");

   midnight_c: cover property (tick && s_q.run && s_q.tm.hour == 5'h17
      && s_q.tm.minute == 6'h3b && s_q.tm.second == 6'h3b);
   trim_hit_c: cover property (tick && s_q.run && calHit);
   err_rise_c: cover property ($rose(errFlag));
   stopped_c: cover property ($fell(s_q.run));

endmodule

//--- verif/calendar_clock_bench.sv
/*
 Self-checking bench of the calendar clock: fields, packed time, rollover,
 trim, run/stop, time source, error pins and interrupt, over APB.
 Assumes the design's short sim parameters and a 40 MHz clock.
*/
`timescale 1ns/1ps
`include "rtc_consts.svh"

module calendar_clock_bench;
   localparam int          TC  = 8;
   localparam int          CW  = 20;
   localparam logic [11:0] CTL = `RTC_CTRL_OFS;
   localparam logic [11:0] ST  = `RTC_IRQST_OFS;
   localparam logic [11:0] MSK = `RTC_IRQMSK_OFS;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic        xtalIn, xtalRun, modulePresent, batteryOk, timeLost;
   logic        clockCorrupt, errFlag, errLed;
   int          miscompares, cmp_count, cyc, h, m, s, y, w, t;
   int          cy[4] = '{2024, 2023, 1999, 2024};
   int          cm[4] = '{2, 2, 12, 4};
   int          cd[4] = '{28, 28, 31, 30};
   int          cw[4] = '{3, 2, 7, 2};
   int          ey[4] = '{2024, 2023, 2000, 2024};
   int          em[4] = '{2, 3, 1, 5};
   int          ed[4] = '{29, 1, 1, 1};

   calendar_clock #(.TICK_CYCLES(TC), .XTAL_DIV(4), .CAL_WINDOW_S(CW)) uut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xtalIn(xtalIn), .modulePresent(modulePresent),
      .batteryOk(batteryOk), .timeLost(timeLost), .clockCorrupt(clockCorrupt),
      .irq(irq), .errFlag(errFlag), .errLed(errLed));

   // free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard, generous against a few thousand cycles of tests
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         miscompares++;
         test_done;
      end
   end

   // crystal stand-in, ten clk cycles a period, still when not wanted
   always @(posedge clk) begin
      if (xtalRun && cyc % 5 == 0) begin
         xtalIn <= ~xtalIn;
      end
   end

   function automatic logic [31:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] hms(input int hh, input int mm, input int ss);
      return 32'(hh * 10000 + mm * 100 + ss);
   endfunction

   task automatic test_done;
      $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // window check; an unknown value fails the ternary
   task automatic near(input logic [31:0] v, input int e, input int tol);
      chk((v >= e - tol && v <= e + tol) ? 32'h1 : 32'h0, 32'h1);
   endtask

   // one APB transfer, entered just after a rising edge
   // only the hang guard ends a wait for pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk(pslverr, e);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(rd, e);
   endtask

   task automatic cmd(input logic [7:0] arg);
      wr(CTL, {16'h0, `RTC_CMD_SEL, arg});
   endtask

   task automatic rst_pulse;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask

   // main sequence
   initial begin
      seed = 32'he7c0bc46;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {xtalIn, xtalRun, modulePresent, timeLost, clockCorrupt} = '0;
      batteryOk = 1'b1;
      {miscompares, cmp_count} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(`RTC_YEAR_OFS, 32'h7d0);
      rdc(`RTC_MONTH_OFS, 32'h1);
      rdc(`RTC_DAY_OFS, 32'h1);
      rdc(`RTC_DOW_OFS, 32'h6);
      rdc(CTL, 32'h3);
      apb(1'b0, 12'h030, 32'h0, 1'b1);
      chk(rd, 32'h0);
      $display("test reset done");
      // fields loaded while stopped, so no tick can move them
      cmd(8'h00);
      rdc(CTL, 32'h2);
      for (int i = 0; i < 5; i++) begin
         h = (i == 0) ? 23 : rnd() % 24;
         m = (i == 0) ? 59 : rnd() % 60;
         s = (i == 0) ? 59 : rnd() % 60;
         y = 1000 + rnd() % 9000;
         w = 1 + rnd() % 7;
         wr(`RTC_HOUR_OFS, h);
         wr(`RTC_MIN_OFS, m);
         wr(`RTC_SEC_OFS, s);
         wr(`RTC_YEAR_OFS, y);
         wr(`RTC_DOW_OFS, w);
         wr(`RTC_HMS_OFS, 32'h0);
         repeat (3 * TC) @(posedge clk);
         rdc(`RTC_SEC_OFS, s);
         rdc(`RTC_MIN_OFS, m);
         rdc(`RTC_HOUR_OFS, h);
         rdc(`RTC_YEAR_OFS, y);
         rdc(`RTC_DOW_OFS, w);
         rdc(`RTC_HMS_OFS, hms(h, m, s));
      end
      $display("test fields done");
      // midnight rollovers raise the day interrupt
      for (int i = 0; i < 4; i++) begin
         wr(`RTC_YEAR_OFS, cy[i]);
         wr(`RTC_MONTH_OFS, cm[i]);
         wr(`RTC_DAY_OFS, cd[i]);
         wr(`RTC_DOW_OFS, cw[i]);
         wr(`RTC_HOUR_OFS, 23);
         wr(`RTC_MIN_OFS, 59);
         wr(`RTC_SEC_OFS, 59);
         wr(ST, 32'h7);
         wr(MSK, 32'h4);
         chk(irq, 1'b0);
         cmd(8'h01);
         t = 0;
         while (irq !== 1'b1 && t < 40) begin
            @(posedge clk);
            t++;
         end
         cmd(8'h00);
         rdc(`RTC_YEAR_OFS, ey[i]);
         rdc(`RTC_MONTH_OFS, em[i]);
         rdc(`RTC_DAY_OFS, ed[i]);
         rdc(`RTC_DOW_OFS, (cw[i] == 7) ? 1 : cw[i] + 1);
         rdc(`RTC_HOUR_OFS, 32'h0);
         wr(MSK, 32'h0);
         chk(irq, 1'b0);
         wr(MSK, 32'h4);
         chk(irq, 1'b1);
         wr(ST, 32'h4);
         chk(irq, 1'b0);
      end
      $display("test rollover done");
      // trim over 40 real seconds; +-2 second slack for run/stop edges
      for (int i = 0; i < 3; i++) begin
         t = (i == 0) ? 10 : (i == 1) ? -10 : 0;
         wr(`RTC_CALIB_OFS, t);
         rdc(`RTC_CALIB_OFS, t);
         wr(`RTC_HOUR_OFS, 0);
         wr(`RTC_MIN_OFS, 0);
         wr(`RTC_SEC_OFS, 0);
         cmd(8'h01);
         repeat (40 * TC) @(posedge clk);
         cmd(8'h00);
         apb(1'b0, `RTC_MIN_OFS, 32'h0, 1'b0);
         m = rd;
         apb(1'b0, `RTC_SEC_OFS, 32'h0, 1'b0);
         near(m * 60 + rd, 40 + t * 40 / CW, 2);
      end
      wr(`RTC_CALIB_OFS, 0);
      $display("test trim done");
      // backup module as time source, crystal still then running
      modulePresent <= 1'b1;
      cmd(8'h03);
      cmd(8'h01);
      rdc(CTL, 32'h7);
      wr(`RTC_SEC_OFS, 0);
      repeat (100) @(posedge clk);
      rdc(`RTC_SEC_OFS, 32'h0);
      xtalRun <= 1'b1;
      repeat (400) @(posedge clk);
      apb(1'b0, `RTC_SEC_OFS, 32'h0, 1'b0);
      near(rd, 10, 2);
      cmd(8'h02);
      rdc(CTL, 32'h5);
      xtalRun <= 1'b0;
      wr(`RTC_SEC_OFS, 0);
      repeat (10 * TC) @(posedge clk);
      apb(1'b0, `RTC_SEC_OFS, 32'h0, 1'b0);
      near(rd, 10, 2);
      modulePresent <= 1'b0;
      $display("test source done");
      // short battery dropout and corruption, each with the error interrupt
      for (int k = 0; k < 2; k++) begin
         wr(ST, 32'h7);
         wr(MSK, 32'h2);
         if (k == 0) begin
            batteryOk <= 1'b0;
         end else begin
            clockCorrupt <= 1'b1;
         end
         repeat (5) @(posedge clk);
         chk(errFlag, 1'b1);
         chk(errLed, 1'b1);
         chk(irq, 1'b1);
         batteryOk <= 1'b1;
         clockCorrupt <= 1'b0;
         repeat (5) @(posedge clk);
         chk(errFlag, 1'b0);
         chk(errLed, 1'b0);
      end
      timeLost <= 1'b1;
      rst_pulse;
      repeat (5) @(posedge clk);
      chk(errFlag, 1'b1);
      timeLost <= 1'b0;
      rst_pulse;
      repeat (5) @(posedge clk);
      chk(errFlag, 1'b0);
      batteryOk <= 1'b0;
      repeat (20 * TC) @(posedge clk);
      batteryOk <= 1'b1;
      repeat (5) @(posedge clk);
      chk(errFlag, 1'b1);
      rst_pulse;
      repeat (5) @(posedge clk);
      chk(errLed, 1'b0);
      $display("test errors done");
      test_done;
   end
endmodule
